// [logic/ldwp_buf2.sv]
// Two-entry valid/ready buffer for memory writes
`timescale 1ns/1ps
module ldwp_buf2
  import ldwp_pkg::*;
#(
  parameter int W = LDWP_ADDR_W + LDWP_BYTE_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  if (W < 1) begin : g_bad_width
    $error("ldwp_buf2 width must be positive");
  end
  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (push) mem_q[wp_q] <= in_data;
  end
endmodule : ldwp_buf2

// [logic/ldwp_write_port.sv]
// Display memory write port: sequential and random-access variants
`timescale 1ns/1ps
module ldwp_write_port
  import ldwp_pkg::*;
#(
  parameter bit RANDOM_ACCESS = 1'b0,
  parameter int DIGITS = LDWP_DIGITS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic write_n,
  input wire logic mode,
  input wire logic [LDWP_BYTE_W-1:0] host_input_lines,
  input wire logic [LDWP_ADDR_W-1:0] digit_select_lines,
  input wire logic format_and_sleep_pin_hi,
  input wire logic format_and_sleep_pin_lo,
  output logic [DIGITS*LDWP_BYTE_W-1:0] display_mem,
  output logic raw_mode,
  output logic hex_font_select,
  output logic sleep,
  output logic accepting
);
  // ****************************************
  // Parameter checks
  // ****************************************
  if (DIGITS != (1 << LDWP_ADDR_W)) begin : g_bad_digits
    $error("DIGITS must match address width");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic wr_s1_q;
  logic wr_s2_q;
  logic wr_s3_q;
  logic md_s1_q;
  logic md_s2_q;
  logic hi_s1_q;
  logic hi_s2_q;
  logic lo_s1_q;
  logic lo_s2_q;
  logic [LDWP_BYTE_W-1:0] d_s1_q;
  logic [LDWP_BYTE_W-1:0] d_s2_q;
  logic [LDWP_ADDR_W-1:0] a_s1_q;
  logic [LDWP_ADDR_W-1:0] a_s2_q;
  logic strobe;

  // Strobe stages reset to the idle level so no false edge follows reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_s1_q <= LDWP_WR_IDLE;
      wr_s2_q <= LDWP_WR_IDLE;
      wr_s3_q <= LDWP_WR_IDLE;
    end else begin
      wr_s1_q <= write_n;
      wr_s2_q <= wr_s1_q;
      wr_s3_q <= wr_s2_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      md_s1_q <= '0;
      md_s2_q <= '0;
    end else begin
      md_s1_q <= mode;
      md_s2_q <= md_s1_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hi_s1_q <= '0;
      hi_s2_q <= '0;
      lo_s1_q <= '0;
      lo_s2_q <= '0;
    end else begin
      hi_s1_q <= format_and_sleep_pin_hi;
      hi_s2_q <= hi_s1_q;
      lo_s1_q <= format_and_sleep_pin_lo;
      lo_s2_q <= lo_s1_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      d_s1_q <= '0;
      d_s2_q <= '0;
    end else begin
      d_s1_q <= host_input_lines;
      d_s2_q <= d_s1_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      a_s1_q <= '0;
      a_s2_q <= '0;
    end else begin
      a_s1_q <= digit_select_lines;
      a_s2_q <= a_s1_q;
    end
  end

  assign strobe = wr_s3_q && !wr_s2_q;

  // ****************************************
  // Sequencer
  // ****************************************
  ldwp_state_t state_q;
  logic [LDWP_ADDR_W-1:0] ptr_q;
  ldwp_fmt_t fmt_q;
  logic seq_ctl;
  logic seq_dat;
  logic in_ready;
  logic in_valid;
  ldwp_word_t in_word;
  ldwp_word_t out_word;
  logic out_valid;
  assign seq_ctl = !RANDOM_ACCESS && strobe && md_s2_q;
  assign seq_dat = !RANDOM_ACCESS && strobe && !md_s2_q && (state_q == LDWP_ST_FILL) && in_ready;

  // Location pointer: cleared by a control word, stepped by each data write in the fill state
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ptr_q <= LDWP_PTR_RST;
    end else if (seq_ctl) begin
      ptr_q <= LDWP_PTR_RST;
    end else if (seq_dat) begin
      ptr_q <= ptr_q + 3'h1;
    end
  end

  // Fill state: opened by a control word, closed after the last location
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= LDWP_ST_IDLE;
    end else if (seq_ctl) begin
      state_q <= d_s2_q[LDWP_CW_MORE] ? LDWP_ST_FILL : LDWP_ST_IDLE;
    end else if (seq_dat) begin
      unique case (state_q)
        LDWP_ST_FILL: begin
          if (ptr_q == LDWP_PTR_LAST) state_q <= LDWP_ST_DONE;
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // ****************************************
  // Format control
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fmt_q <= '0;
    end else if (RANDOM_ACCESS) begin
      fmt_q.raw <= 1'b0;
      fmt_q.hex <= hi_s2_q && lo_s2_q;
      fmt_q.sleep <= !hi_s2_q && !lo_s2_q;
    end else if (seq_ctl) begin
      fmt_q.raw <= d_s2_q[LDWP_CW_RAW];
      fmt_q.hex <= d_s2_q[LDWP_CW_HEX];
      fmt_q.sleep <= !d_s2_q[LDWP_CW_SLEEP_N];
    end
  end
  // ****************************************
  // Write path through buffer
  // ****************************************
  always_comb begin
    in_word = '0;
    in_valid = 1'b0;
    if (RANDOM_ACCESS) begin
      in_valid = strobe;
      in_word.addr = a_s2_q;
      in_word.data[LDWP_DP_BIT] = d_s2_q[LDWP_DP_BIT];
      in_word.data[LDWP_NIB_W-1:0] = d_s2_q[LDWP_NIB_W-1:0];
    end else begin
      in_valid = seq_dat;
      in_word.addr = ptr_q;
      in_word.data = d_s2_q;
    end
  end
  ldwp_buf2 #(.W(LDWP_ADDR_W + LDWP_BYTE_W)) u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_word),
    .out_valid(out_valid),
    .out_ready(1'b1),
    .out_data(out_word)
  );
  genvar gi;
  generate
    for (gi = 0; gi < DIGITS; gi++) begin : g_dig
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          display_mem[gi*LDWP_BYTE_W +: LDWP_BYTE_W] <= LDWP_MEM_RST;
        end else if (out_valid && out_word.addr == LDWP_ADDR_W'(gi)) begin
          display_mem[gi*LDWP_BYTE_W +: LDWP_BYTE_W] <= out_word.data;
        end
      end
    end
  endgenerate
  // ****************************************
  // Registered status outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      raw_mode <= 1'b0;
      hex_font_select <= 1'b0;
      sleep <= 1'b0;
      accepting <= 1'b0;
    end else begin
      raw_mode <= fmt_q.raw;
      hex_font_select <= fmt_q.hex;
      sleep <= fmt_q.sleep;
      accepting <= RANDOM_ACCESS || (state_q == LDWP_ST_FILL);
    end
  end
endmodule : ldwp_write_port

// [pkg/ldwp_pkg.sv]
// Constants, types and the list of behaviours for the display memory write port
// What this block does
// - Random variant: format only from three-level pin
// - Random variant: address plus strobe loads nibble
// - Addressed write leaves other digits untouched
// - Mode high means control, low means data
// - Sequential variant takes a full input byte
// - Data strobes fill next location, pointer auto-advances
// - After eight data strobes ignore until control
// - Pin high hex, floating alternate, low shutdown
// - Control word: raw, decode type, shutdown, data-follows
// - Decoded formats: code low nibble, point top bit
// - Raw mode: ones light, decimal point active low
package ldwp_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int LDWP_DIGITS = 8;
  localparam int LDWP_ADDR_W = 3;
  localparam int LDWP_BYTE_W = 8;
  // ****************************************
  // Control word and data byte field positions
  // ****************************************
  localparam int LDWP_CW_SLEEP_N = 4;
  localparam int LDWP_CW_RAW = 5;
  localparam int LDWP_CW_HEX = 6;
  localparam int LDWP_CW_MORE = 7;
  localparam int LDWP_DP_BIT = 7;
  localparam int LDWP_NIB_W = 4;
  // ****************************************
  // Reset values and last pointer location
  // ****************************************
  localparam logic [LDWP_BYTE_W-1:0] LDWP_MEM_RST = 8'h00;
  localparam logic [LDWP_ADDR_W-1:0] LDWP_PTR_RST = 3'h0;
  localparam logic [LDWP_ADDR_W-1:0] LDWP_PTR_LAST = 3'h7;
  localparam logic LDWP_WR_IDLE = 1'b1;
  // Three-level pin as two digital lines
  typedef enum logic [1:0] {
    LDWP_TL_LOW = 2'h0,
    LDWP_TL_FLOAT = 2'h1,
    LDWP_TL_HIGH = 2'h2
  } ldwp_level_t;
  typedef enum logic [2:0] {
    LDWP_ST_IDLE = 3'h1,
    LDWP_ST_FILL = 3'h2,
    LDWP_ST_DONE = 3'h4
  } ldwp_state_t;
  typedef struct packed {
    logic [LDWP_ADDR_W-1:0] addr;
    logic [LDWP_BYTE_W-1:0] data;
  } ldwp_word_t;
  typedef struct packed {
    logic raw;
    logic hex;
    logic sleep;
  } ldwp_fmt_t;
endpackage : ldwp_pkg

// [test/ldwp_host.sv]
// Host model driving the write port pins
`timescale 1ns/1ps
module ldwp_host
  import ldwp_pkg::*;
(
  input wire logic ref_clk,
  output logic write_n,
  output logic mode,
  output logic [LDWP_BYTE_W-1:0] host_input_lines,
  output logic [LDWP_ADDR_W-1:0] digit_select_lines,
  output logic format_and_sleep_pin_hi,
  output logic format_and_sleep_pin_lo
);
  initial begin
    {write_n, mode, host_input_lines, digit_select_lines} = 13'h1FFF;
    {format_and_sleep_pin_hi, format_and_sleep_pin_lo} = 2'h3;
  end
  // Set up, strobe low two cycles, hold, then drive the complement on the data lines
  task automatic wr(input logic m, input logic [7:0] d, input logic [2:0] a);
    @(posedge ref_clk) #1 {mode, host_input_lines, digit_select_lines} = {m, d, a};
    repeat (4) @(posedge ref_clk);
    #1 write_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 write_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 host_input_lines = ~d;
    repeat (6) @(posedge ref_clk);
  endtask : wr
  task automatic pin(input logic [1:0] v);
    @(posedge ref_clk) #1 {format_and_sleep_pin_hi, format_and_sleep_pin_lo} = v;
    repeat (8) @(posedge ref_clk);
  endtask : pin
endmodule : ldwp_host

// [test/ldwp_write_port_checker.sv]
// Assertions on the write port pins
`timescale 1ns/1ps
module ldwp_write_port_checker
  import ldwp_pkg::*;
#(
  parameter bit RANDOM_ACCESS = 1'b0,
  parameter int DIGITS = LDWP_DIGITS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic write_n,
  input wire logic mode,
  input wire logic [LDWP_BYTE_W-1:0] host_input_lines,
  input wire logic [LDWP_ADDR_W-1:0] digit_select_lines,
  input wire logic format_and_sleep_pin_hi,
  input wire logic format_and_sleep_pin_lo,
  input wire logic [DIGITS*LDWP_BYTE_W-1:0] display_mem,
  input wire logic raw_mode,
  input wire logic hex_font_select,
  input wire logic sleep,
  input wire logic accepting
);
  logic [DIGITS*LDWP_BYTE_W-1:0] mem_q;
  logic [DIGITS-1:0] chg;
  always_ff @(posedge ref_clk) begin
    mem_q <= display_mem;
  end
  always_comb begin
    for (int i = 0; i < DIGITS; i++) begin
      chg[i] = display_mem[8*i+:8] != mem_q[8*i+:8];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_pin_level: assert property (RANDOM_ACCESS && $stable({format_and_sleep_pin_hi,
    format_and_sleep_pin_lo})[*8] |-> {hex_font_select, raw_mode, sleep} ==
    {format_and_sleep_pin_hi & format_and_sleep_pin_lo, 1'b0,
    ~format_and_sleep_pin_hi & ~format_and_sleep_pin_lo}) else $error("pin level");
  chk_mem_quiet: assert property ($stable(write_n)[*8] |-> $stable(display_mem))
    else $error("mem changed");
  chk_fmt_quiet: assert property (!RANDOM_ACCESS && $stable(write_n)[*8] |->
    $stable({raw_mode, hex_font_select, sleep, accepting})) else $error("fmt changed");
  chk_one_digit: assert property ($onehot0(chg)) else $error("many digits");
  chk_ra_format: assert property (RANDOM_ACCESS |->
    (display_mem & {DIGITS{8'h70}}) == '0) else $error("ra format");
  chk_ctrl_fields: assert property (!RANDOM_ACCESS && $fell(write_n) && mode |-> ##6
    {accepting, hex_font_select, raw_mode, sleep} == ($past(host_input_lines[7:4], 6) ^ 4'h1))
    else $error("ctrl fields");
  chk_idle_drop: assert property (!RANDOM_ACCESS && !accepting && $fell(write_n) && !mode
    |=> $stable(display_mem)[*6]) else $error("idle write");
  chk_ra_store: assert property (RANDOM_ACCESS && $fell(write_n) |-> ##6
    display_mem[8*$past(digit_select_lines, 6)+:8] == {$past(host_input_lines[7], 6),
    3'h0, $past(host_input_lines[3:0], 6)}) else $error("ra store");
endmodule : ldwp_write_port_checker
bind ldwp_write_port ldwp_write_port_checker #(.RANDOM_ACCESS(RANDOM_ACCESS),
  .DIGITS(DIGITS)) chk (.*);

// [test/led_display_memory_write_port_test.sv]
// Self-checking bench for both write port variants
`timescale 1ns/1ps
module led_display_memory_write_port_test;
  import ldwp_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic write_n, mode, format_and_sleep_pin_hi, format_and_sleep_pin_lo;
  logic [7:0] host_input_lines;
  logic [2:0] digit_select_lines;
  logic [63:0] mem_s, mem_r, exp;
  logic [3:0] fmt_s, fmt_r;
  logic [7:0] cw [4] = '{8'hF0, 8'h20, 8'h50, 8'h00};
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  always #10 ref_clk = ~ref_clk;
  ldwp_host host (.*);
  ldwp_write_port uut (.*, .display_mem(mem_s), .raw_mode(fmt_s[1]),
    .hex_font_select(fmt_s[2]), .sleep(fmt_s[0]), .accepting(fmt_s[3]));
  ldwp_write_port #(.RANDOM_ACCESS(1'b1)) uut_ra (.*, .display_mem(mem_r),
    .raw_mode(fmt_r[1]), .hex_font_select(fmt_r[2]), .sleep(fmt_r[0]), .accepting(fmt_r[3]));
  task automatic check(input string what, input logic [63:0] e, input logic [63:0] got);
    n_compared++;
    if (got !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask : check
  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  // Random variant: addressed digits and the three-level pin
  task automatic t_ra();
    host.wr(1'b0, 8'hFF, 3'h7);
    host.wr(1'b0, 8'h35, 3'h2);
    check("ra_mem", 64'h8F00000000050000, mem_r);
    check("ra_acc", 64'h1, fmt_r[3]);
    for (int i = 0; i < 4; i++) begin
      host.pin(2'(3 - i));
      check("ra_fmt", {i == 0, 1'b0, i == 3}, fmt_r[2:0]);
    end
  endtask : t_ra
  // Control words set the format levels and gate data
  task automatic t_ctrl();
    foreach (cw[i]) begin
      host.wr(1'b1, cw[i], 3'h0);
      check("fmt", cw[i][7:4] ^ 4'h1, fmt_s);
    end
    host.wr(1'b0, 8'h5A, 3'h0);
    check("idle_mem", 64'h0, mem_s);
  endtask : t_ctrl
  // Raw fill of all eight locations, then one extra strobe
  task automatic t_fill();
    host.wr(1'b1, 8'hB0, 3'h0);
    for (int i = 0; i < 8; i++) begin
      exp[8*i+:8] = 8'(8'h11 * (i + 1)) ^ 8'h80;
      host.wr(1'b0, exp[8*i+:8], 3'(7 - i));
    end
    host.wr(1'b0, 8'hEE, 3'h0);
    check("fill_mem", exp, mem_s);
    check("fill_acc", 64'h0, fmt_s[3]);
  endtask : t_fill
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 resetn = 1'b1;
    check("rst_mem", 64'h0, mem_s);
    t_ra();
    t_ctrl();
    t_fill();
    final_report();
  end
endmodule : led_display_memory_write_port_test
